// ==== verilog/ectm_consts.svh ====
// Offsets, field positions, reset values and counts of the edge capture timer
`ifndef ECTM_CONSTS_SVH
`define ECTM_CONSTS_SVH
`define ECTM_OFS_CTRL 8'h00
`define ECTM_OFS_FALL 8'h04
`define ECTM_OFS_RISE 8'h08
`define ECTM_OFS_PORT 8'h0c
`define ECTM_OFS_IRQ 8'h10
`define ECTM_BIT_WRAP_HI 7
`define ECTM_BIT_WRAP_LO 6
`define ECTM_BIT_WRAP_IE 5
`define ECTM_BIT_EDGE_SEL 4
`define ECTM_BIT_CLR_HI 3
`define ECTM_BIT_CLR_LO 2
`define ECTM_BIT_CKS_HI 1
`define ECTM_BIT_CKS_LO 0
`define ECTM_BIT_CAP_SEL 0
`define ECTM_BIT_FILT_EN 1
`define ECTM_BIT_IRQ_REQ 0
`define ECTM_CTRL_RST 8'h00
`define ECTM_CNT_RST 8'h00
`define ECTM_CAPT_RST 8'h00
`define ECTM_PRE_W 6
`define ECTM_PRE_DIV64_BIT 5
`define ECTM_PRE_DIV32_BIT 4
`define ECTM_PRE_DIV2_BIT 0
`define ECTM_FILT_TAPS 5
`define ECTM_CNT_W 8
`endif

// ==== verilog/ectm_pkg.sv ====
// Types of the edge capture timer
package ectm_pkg;
	typedef enum logic [1:0] {
		ECTM_BUS_IDLE = 2'b01,
		ECTM_BUS_ACK = 2'b10
	} ectm_bus_st_t;
	typedef enum logic [1:0] {
		ECTM_CK_DIV64 = 2'b00,
		ECTM_CK_DIV32 = 2'b01,
		ECTM_CK_DIV2 = 2'b10,
		ECTM_CK_WATCH2 = 2'b11
	} ectm_clk_sel_t;
endpackage

// ==== verilog/ectm_top.sv ====
// Edge capture timer with noise filter and classic Wishbone registers
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "ectm_consts.svh"
`default_nettype none

module ectm_top
	import ectm_pkg::*;
#(
	parameter int CNT_W = `ECTM_CNT_W,
	parameter int FILT_TAPS = `ECTM_FILT_TAPS
) (
	input wire logic MCLK, // System clock, 20 MHz
	input wire logic RESET, // Synchronous reset, active high
	input wire logic [7:0] WB_ADR_I, // Byte address
	input wire logic [31:0] WB_DAT_I, // Write data
	input wire logic [3:0] WB_SEL_I, // Byte lanes
	input wire logic WB_WE_I, // Write strobe
	input wire logic WB_CYC_I, // Bus cycle
	input wire logic WB_STB_I, // Strobe
	output logic [31:0] WB_DAT_O, // Read data
	output logic WB_ACK_O, // Acknowledge
	input wire logic CAPT_IN, // Capture input pin
	input wire logic WATCH_CLK, // Watch clock pin
	output logic TIMER_IRQ_REQ // Timer request flag
);

	localparam logic [2:0] FILL_MAX = 3'(FILT_TAPS);
	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
	localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(`ECTM_CNT_RST);
	localparam logic [CNT_W-1:0] CAPT_ZERO = CNT_W'(`ECTM_CAPT_RST);

	// Bus state
	ectm_bus_st_t bus_st_q;
	ectm_bus_st_t bus_st_d;
	logic [31:0] rd_q;
	logic ack_q;

	// Control fields
	logic wrap_hi_q;
	logic wrap_lo_q;
	logic arm_hi_q;
	logic arm_lo_q;
	logic wrap_ie_q;
	logic edge_sel_q;
	logic clear_sel_hi_q;
	logic clear_sel_lo_q;
	logic [1:0] cks_q;
	logic cap_sel_q;
	logic filt_en_q;
	logic irq_q;

	// Timing and capture state
	logic [`ECTM_PRE_W-1:0] pre_q;
	logic watch_s1_q;
	logic watch_s2_q;
	logic watch_prev_q;
	logic watch_div_q;
	logic sel_prev_q;
	logic samp_prev_q;
	logic cap_s1_q;
	logic cap_s2_q;
	logic [FILT_TAPS-1:0] taps_q;
	logic [2:0] fill_q;
	logic filt_valid_q;
	logic filt_q;
	logic cap_prev_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] rise_cap_q;
	logic [CNT_W-1:0] fall_cap_q;

	// Bus decode
	wire req = WB_CYC_I & WB_STB_I & (bus_st_q == ECTM_BUS_IDLE);
	wire wr_lane0 = req & WB_WE_I & WB_SEL_I[0];
	wire rd_req = req & ~WB_WE_I;
	wire hit_ctrl = (WB_ADR_I == `ECTM_OFS_CTRL);
	wire hit_fall = (WB_ADR_I == `ECTM_OFS_FALL);
	wire hit_rise = (WB_ADR_I == `ECTM_OFS_RISE);
	wire hit_port = (WB_ADR_I == `ECTM_OFS_PORT);
	wire hit_irq = (WB_ADR_I == `ECTM_OFS_IRQ);
	wire wr_ctrl = wr_lane0 & hit_ctrl;
	wire wr_port = wr_lane0 & hit_port;
	wire wr_irq = wr_lane0 & hit_irq;
	wire rd_ctrl = rd_req & hit_ctrl;

	wire [7:0] ctrl_view = {wrap_hi_q, wrap_lo_q, wrap_ie_q, edge_sel_q,
		clear_sel_hi_q, clear_sel_lo_q, cks_q};
	wire [7:0] port_view = {6'h00, filt_en_q, cap_sel_q};
	wire [7:0] irq_view = {7'h00, irq_q};
	// Counter itself has no address
	wire [7:0] rd_byte = hit_ctrl ? ctrl_view :
		hit_fall ? 8'(fall_cap_q) :
		hit_rise ? 8'(rise_cap_q) :
		hit_port ? port_view :
		hit_irq ? irq_view : 8'h00;

	// One answer per request, then back to idle
	always_comb begin
		case (bus_st_q)
			ECTM_BUS_IDLE: begin
				bus_st_d = req ? ECTM_BUS_ACK : ECTM_BUS_IDLE;
			end
			ECTM_BUS_ACK: begin
				bus_st_d = ECTM_BUS_IDLE;
			end
			default: begin
				bus_st_d = ECTM_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			bus_st_q <= ECTM_BUS_IDLE;
			ack_q <= 1'b0;
		end else begin
			bus_st_q <= bus_st_d;
			ack_q <= (bus_st_d == ECTM_BUS_ACK);
		end
	end

	// Read data stands only in the answer cycle
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			rd_q <= 32'h00000000;
		end else begin
			rd_q <= rd_req ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end

	// Prescaler of the system clock
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			pre_q <= `ECTM_PRE_W'(0);
		end else begin
			pre_q <= `ECTM_PRE_W'(pre_q + `ECTM_PRE_W'(1));
		end
	end

	// Watch clock pin, two flops, then halved
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			watch_s1_q <= 1'b0;
			watch_s2_q <= 1'b0;
			watch_prev_q <= 1'b0;
			watch_div_q <= 1'b0;
		end else begin
			watch_s1_q <= WATCH_CLK;
			watch_s2_q <= watch_s1_q;
			watch_prev_q <= watch_s2_q;
			watch_div_q <= watch_div_q ^ (watch_s2_q & ~watch_prev_q);
		end
	end

	// Selected counting clock
	wire sel_clk = (cks_q == ECTM_CK_DIV64) ? pre_q[`ECTM_PRE_DIV64_BIT] :
		(cks_q == ECTM_CK_DIV32) ? pre_q[`ECTM_PRE_DIV32_BIT] :
		(cks_q == ECTM_CK_DIV2) ? pre_q[`ECTM_PRE_DIV2_BIT] : watch_div_q;
	// Select change from high to low also counts
	wire tick = sel_prev_q & ~sel_clk;
	wire samp_rise = sel_clk & ~samp_prev_q;
	wire samp = filt_en_q ? samp_rise : 1'b1;

	// Capture pin synchronizer, counting clock history and filter taps
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			cap_s1_q <= 1'b0;
			cap_s2_q <= 1'b0;
			sel_prev_q <= 1'b0;
			samp_prev_q <= 1'b0;
		end else begin
			cap_s1_q <= CAPT_IN;
			cap_s2_q <= cap_s1_q;
			sel_prev_q <= sel_clk;
			samp_prev_q <= sel_clk;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < FILT_TAPS; gi = gi + 1) begin : g_tap
			wire tap_in;
			if (gi == 0) begin : g_first
				assign tap_in = cap_s2_q;
			end else begin : g_rest
				assign tap_in = taps_q[gi-1];
			end
			always_ff @(posedge MCLK) begin
				if (RESET) begin
					taps_q[gi] <= 1'b0;
				end else if (samp) begin
					taps_q[gi] <= tap_in;
				end
			end
		end
	endgenerate

	// Match detection over the taps
	wire all_hi = &taps_q;
	wire all_lo = ~|taps_q;
	wire fill_done = (fill_q == FILL_MAX);
	wire [2:0] fill_d = (samp & ~fill_done) ? 3'(fill_q + 3'h1) : fill_q;
	wire filt_valid_d = filt_valid_q | (fill_done & all_lo);
	wire filt_d = ~filt_valid_q ? 1'b0 :
		all_hi ? 1'b1 : all_lo ? 1'b0 : filt_q;

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			fill_q <= 3'h0;
			filt_valid_q <= 1'b0;
			filt_q <= 1'b0;
		end else begin
			fill_q <= fill_d;
			filt_valid_q <= filt_valid_d;
			filt_q <= filt_d;
		end
	end

	// Capture level; a mode switch can make a spurious edge
	wire filt_sel = filt_en_q ? filt_q : cap_s2_q;
	wire cap_lvl = cap_sel_q ? filt_sel : 1'b0;
	wire rise_e = cap_lvl & ~cap_prev_q;
	wire fall_e = ~cap_lvl & cap_prev_q;

	// Count, clear and capture; a capture keeps the count before a clear
	wire clr_now = (rise_e & clear_sel_hi_q) | (fall_e & clear_sel_lo_q);
	wire wrap = tick & (cnt_q == CNT_MAX) & ~clr_now;
	wire [CNT_W-1:0] cnt_d = clr_now ? CNT_ZERO :
		tick ? CNT_W'(cnt_q + CNT_W'(1)) : cnt_q;
	wire [CNT_W-1:0] rise_cap_d = rise_e ? cnt_q : rise_cap_q;
	wire [CNT_W-1:0] fall_cap_d = fall_e ? cnt_q : fall_cap_q;

	// Counter and previous capture level
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			cap_prev_q <= 1'b0;
			cnt_q <= CNT_ZERO;
		end else begin
			cap_prev_q <= cap_lvl;
			cnt_q <= cnt_d;
		end
	end

	// Capture registers
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			rise_cap_q <= CAPT_ZERO;
			fall_cap_q <= CAPT_ZERO;
		end else begin
			rise_cap_q <= rise_cap_d;
			fall_cap_q <= fall_cap_d;
		end
	end

	// Wrap flags; set wins over a clear in the same cycle
	wire set_hi = wrap & cap_lvl;
	wire set_lo = wrap & ~cap_lvl;
	wire clr_hi = wr_ctrl & ~WB_DAT_I[`ECTM_BIT_WRAP_HI] & arm_hi_q;
	wire clr_lo = wr_ctrl & ~WB_DAT_I[`ECTM_BIT_WRAP_LO] & arm_lo_q;
	wire wrap_hi_d = set_hi | (wrap_hi_q & ~clr_hi);
	wire wrap_lo_d = set_lo | (wrap_lo_q & ~clr_lo);
	wire arm_hi_d = (rd_ctrl & wrap_hi_q) | (arm_hi_q & ~clr_hi);
	wire arm_lo_d = (rd_ctrl & wrap_lo_q) | (arm_lo_q & ~clr_lo);

	// Timer request
	wire edge_req = edge_sel_q ? fall_e : rise_e;
	wire wrap_req = (set_hi | set_lo) & wrap_ie_q;
	wire irq_clr = wr_irq & ~WB_DAT_I[`ECTM_BIT_IRQ_REQ];
	wire irq_d = edge_req | wrap_req | (irq_q & ~irq_clr);

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			wrap_hi_q <= 1'(`ECTM_CTRL_RST >> `ECTM_BIT_WRAP_HI);
			wrap_lo_q <= 1'(`ECTM_CTRL_RST >> `ECTM_BIT_WRAP_LO);
			arm_hi_q <= 1'b0;
			arm_lo_q <= 1'b0;
		end else begin
			wrap_hi_q <= wrap_hi_d;
			wrap_lo_q <= wrap_lo_d;
			arm_hi_q <= arm_hi_d;
			arm_lo_q <= arm_lo_d;
		end
	end

	// Timer request flag
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// Software fields
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			wrap_ie_q <= 1'b0;
			edge_sel_q <= 1'b0;
			clear_sel_hi_q <= 1'b0;
			clear_sel_lo_q <= 1'b0;
			cks_q <= ECTM_CK_DIV64;
		end else if (wr_ctrl) begin
			wrap_ie_q <= WB_DAT_I[`ECTM_BIT_WRAP_IE];
			edge_sel_q <= WB_DAT_I[`ECTM_BIT_EDGE_SEL];
			clear_sel_hi_q <= WB_DAT_I[`ECTM_BIT_CLR_HI];
			clear_sel_lo_q <= WB_DAT_I[`ECTM_BIT_CLR_LO];
			cks_q <= WB_DAT_I[`ECTM_BIT_CKS_HI:`ECTM_BIT_CKS_LO];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			cap_sel_q <= 1'b0;
			filt_en_q <= 1'b0;
		end else if (wr_port) begin
			cap_sel_q <= WB_DAT_I[`ECTM_BIT_CAP_SEL];
			filt_en_q <= WB_DAT_I[`ECTM_BIT_FILT_EN];
		end
	end

	assign WB_DAT_O = rd_q;
	assign WB_ACK_O = ack_q;
	assign TIMER_IRQ_REQ = irq_q;

endmodule // ectm_top

`default_nettype wire

// ==== sim/ectm_properties.sv ====
// Port properties of the edge capture timer
`timescale 1ns/1ps
`include "ectm_consts.svh"
`default_nettype none
module ectm_properties (
	input wire logic MCLK, // Clock
	input wire logic RESET, // Reset
	input wire logic [7:0] WB_ADR_I, // Address
	input wire logic [31:0] WB_DAT_I, // Data in
	input wire logic [3:0] WB_SEL_I, // Lanes
	input wire logic WB_WE_I, // Write
	input wire logic WB_CYC_I, // Cycle
	input wire logic WB_STB_I, // Strobe
	input wire logic [31:0] WB_DAT_O, // Data out
	input wire logic WB_ACK_O, // Ack
	input wire logic CAPT_IN, // Pin
	input wire logic WATCH_CLK, // Watch clock
	input wire logic TIMER_IRQ_REQ // Request
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RESET);
	sequence s_take;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence s_odd_rd;
		s_take ##0 (!WB_WE_I && WB_ADR_I > `ECTM_OFS_IRQ);
	endsequence
	a_ack_follows: assert property (s_take |=> WB_ACK_O) else $error("no ack");
	a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("long ack");
	a_ack_cause: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
		else $error("stray ack");
	a_dat_quiet: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("idle data");
	a_dat_narrow: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
		else $error("upper bits");
	a_odd_zero: assert property (s_odd_rd |=> WB_DAT_O == 32'h0) else $error("unmapped data");
	a_irq_sticky: assert property (TIMER_IRQ_REQ && !(WB_CYC_I && WB_STB_I && WB_WE_I
		&& WB_ADR_I == `ECTM_OFS_IRQ) |=> TIMER_IRQ_REQ) else $error("request lost");
	a_reset_quiet: assert property (disable iff (1'b0) RESET |=> !WB_ACK_O && !TIMER_IRQ_REQ)
		else $error("busy after reset");
endmodule // ectm_properties
`default_nettype wire

// ==== sim/ectm_pulse_src.sv ====
// Far-side pulse source for the capture pin
`timescale 1ns/1ps
`default_nettype none
module ectm_pulse_src (
	input wire logic clk, // Clock
	input wire logic go, // Start
	input wire logic [15:0] hi_len, // High clocks
	output logic pin, // Pin
	output logic busy // In pulse
);
	logic [15:0] cnt_q;
	initial {pin, busy, cnt_q} = '0;
	always @(posedge clk) begin
		if (go && !busy) begin
			pin <= 1'b1;
			busy <= 1'b1;
			cnt_q <= (hi_len < 16'h0002) ? 16'h0002 : hi_len;
		end else if (cnt_q > 16'h0001) begin
			cnt_q <= cnt_q - 16'h0001;
		end else begin
			pin <= 1'b0;
			busy <= 1'b0;
		end
	end
endmodule // ectm_pulse_src
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench of the edge capture timer
`timescale 1ns/1ps
`include "ectm_consts.svh"
`default_nettype none
module tb_top
	import ectm_pkg::*;
;
	localparam logic [7:0] CT = `ECTM_OFS_CTRL, IQ = `ECTM_OFS_IRQ, PT = `ECTM_OFS_PORT;
	logic mclk, reset, we, cyc, stb, wclk, go, busy, capt, ack, irq;
	logic [7:0] adr;
	logic [31:0] di, dout, v;
	logic [3:0] sel;
	logic [15:0] hlen;
	logic [95:0] e;
	logic [95:0] exp_q[$];
	int errors, num_checks, h;
	int div[4] = '{64, 32, 2, 16};
	ectm_top dut (.MCLK(mclk), .RESET(reset), .WB_ADR_I(adr), .WB_DAT_I(di), .WB_SEL_I(sel),
		.WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dout), .WB_ACK_O(ack),
		.CAPT_IN(capt), .WATCH_CLK(wclk), .TIMER_IRQ_REQ(irq));
	ectm_pulse_src src (.clk(mclk), .go(go), .hi_len(hlen), .pin(capt), .busy(busy));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		wclk = 1'b0;
		forever #203 wclk = ~wclk;
	end
	task automatic give_verdict;
		$display("CHECKS %0d ERRORS %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic hang;
		errors++;
		give_verdict();
	endtask
	task automatic irq_pin(input logic x);
		num_checks++;
		if (irq !== x) begin
			errors++;
			$display("ERROR irq pin expected %b seen %b", x, irq);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		adr <= a;
		we <= w;
		di <= {24'h0, d};
		cyc <= 1'b1;
		stb <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
		if (n >= 50) hang();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] lo, hi, m);
		exp_q.push_back({lo, hi, m});
		xfer(a, 1'b0, 8'h00);
	endtask
	task automatic pulse(input int len);
		int n;
		hlen <= len[15:0];
		go <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			go <= 1'b0;
			n++;
		end while ((busy === 1'b1 || n < 2) && n < 5000);
		if (n >= 5000) hang();
		repeat (80) @(posedge mclk);
	endtask
	always @(posedge mclk) begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			v = dout & e[31:0];
			num_checks++;
			if ((v >= e[95:64] && v <= e[63:32]) !== 1'b1) begin
				errors++;
				$display("ERROR read %h expected %h..%h seen %h", adr, e[95:64], e[63:32], v);
			end
		end
	end
	initial begin
		repeat (100000) @(posedge mclk);
		hang();
	end
	initial begin
		errors = 0;
		num_checks = 0;
		{cyc, stb, we, go, adr, di, hlen} = '0;
		reset = 1'b1;
		sel = 4'h1;
		void'($urandom(32'hd6d3));
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		for (int i = 0; i < 6; i++) rd(8'(i * 4), 0, 0, '1);
		sel <= 4'h0;
		wr(CT, 8'h3f);
		sel <= 4'h1;
		wr(`ECTM_OFS_RISE, 8'hff);
		rd(CT, 0, 0, '1);
		rd(`ECTM_OFS_RISE, 0, 0, '1);
		wr(CT, 8'hff);
		rd(CT, 32'h3f, 32'h3f, '1);
		$display("Test access done");
		wr(CT, 8'h22);
		repeat (600) @(posedge mclk);
		rd(CT, 32'h40, 32'h40, 32'hc0);
		rd(IQ, 1, 1, '1);
		irq_pin(1'b1);
		wr(CT, 8'h22);
		wr(IQ, 8'h00);
		rd(CT, 32'h22, 32'h22, '1);
		rd(IQ, 0, 0, '1);
		irq_pin(1'b0);
		$display("Test interval done");
		wr(PT, 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(CT, {6'h03, ectm_clk_sel_t'(i)});
			pulse(4 * div[i]);
			rd(`ECTM_OFS_FALL, 3, 5, 32'hff);
		end
		rd(IQ, 1, 1, '1);
		wr(IQ, 8'h00);
		wr(CT, 8'h1a);
		for (int k = 0; k < 4; k++) begin
			h = 8 + 2 * ($urandom % 60);
			pulse(h);
			rd(`ECTM_OFS_FALL, h / 2 - 1, h / 2 + 1, 32'hff);
		end
		rd(IQ, 1, 1, '1);
		wr(CT, 8'h02);
		rd(CT, 32'h02, 32'h02, '1);
		wr(CT, 8'h02);
		pulse(600);
		rd(CT, 32'h80, 32'h80, 32'h80);
		$display("Test capture done");
		wr(PT, 8'h00);
		wr(PT, 8'h02);
		wr(PT, 8'h03);
		wr(CT, 8'h12);
		wr(IQ, 8'h00);
		pulse(4);
		rd(IQ, 0, 0, '1);
		pulse(40);
		rd(IQ, 1, 1, '1);
		irq_pin(1'b1);
		$display("Test filter done");
		reset <= 1'b1;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		for (int i = 0; i < 5; i++) rd(8'(i * 4), 0, 0, '1);
		irq_pin(1'b0);
		$display("Test reset done");
		give_verdict();
	end
endmodule // tb_top
bind ectm_top ectm_properties chk (.MCLK, .RESET, .WB_ADR_I, .WB_DAT_I, .WB_SEL_I, .WB_WE_I,
	.WB_CYC_I, .WB_STB_I, .WB_DAT_O, .WB_ACK_O, .CAPT_IN, .WATCH_CLK, .TIMER_IRQ_REQ);
`default_nettype wire
